/* File: logic/ovwd_decoder.sv */
/*
 Display-list word decoder with a classic Wishbone register slave.
 Software writes a 12-bit word at WORD; the decoder classifies it and
 publishes the decoded fields in status registers and top-level outputs.
 Assumes one 100 MHz clock and a master that holds requests until ack.
*/
// The register offsets and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ovwd_decoder #(
   parameter int ENTRY_W = 8
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic word_valid,
   output logic [2:0] word_kind,
   output logic [2:0] char_color,
   output logic [15:0] glyph_addr,
   output logic [ENTRY_W-1:0] fetch_index,
   output logic [3:0] line_vsize,
   output logic [7:0] line_height,
   output logic [3:0] line_voffset,
   output logic [3:0] line_hshift,
   output logic [10:0] char_attr,
   output logic [7:0] attr_span
);
   if (ENTRY_W < 4 || ENTRY_W > 16) begin : g_bad_entry_w
      $error("ENTRY_W out of range");
   end

   function automatic logic [7:0] height_of(input logic [3:0] v);
      height_of = 8'(ovwd_pkg::LINES_PER_SIZE * (int'(v) + 1));
   endfunction

   logic ack_q;
   logic started_q, started_d;
   logic line_start_q, line_start_d;
   logic ctrl_pend_q, ctrl_pend_d;
   logic valid_q;
   logic [2:0] kind_q, kind_d;
   logic [2:0] color_q, color_d;
   logic [15:0] glyph_q, glyph_d;
   logic [ENTRY_W-1:0] index_q, index_d;
   logic [3:0] vsize_q, vsize_d;
   logic [7:0] height_q, height_d;
   logic [3:0] voff_q, voff_d;
   logic [3:0] hshift_q, hshift_d;
   logic [10:0] attr_q, attr_d;
   logic [7:0] span_q, span_d;
   logic [7:0] pending_q, pending_d;
   logic [11:0] origin_q;
   logic [11:0] last_word_q;
   logic [31:0] rdata_q;

   wire logic req;
   wire logic wr;
   wire logic word_wr;
   wire logic [11:0] w;
   wire logic tag;
   wire logic [10:0] dfield;
   wire logic is_ptr;
   wire logic is_line_end;
   wire logic is_screen_end;
   wire logic is_line_ctrl;
   wire logic [15:0] gfirst;
   wire logic [31:0] rd_mux;

   assign req = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr = req && wb_we_i && wb_sel_i[0];
   assign word_wr = wr && (wb_adr_i == ovwd_pkg::ADDR_WORD);
   // Only the low 12 bits carry a word; upper lanes are ignored.
   assign w = wb_dat_i[ovwd_pkg::WORD_W-1:0];
   assign tag = w[ovwd_pkg::TAG_BIT];
   assign dfield = w[ovwd_pkg::TAG_BIT-1:0];
   assign is_ptr = !tag && dfield == ovwd_pkg::MARK_PTR_RESET;
   assign is_line_end = !tag && dfield == ovwd_pkg::MARK_LINE_END;
   assign is_screen_end = !tag && dfield == ovwd_pkg::MARK_SCREEN_END;
   // Position decides control words, so a line control never reads as a marker.
   assign is_line_ctrl = !started_q || line_start_q;

   ovwd_glyph_map u_map (
      .index(w[ovwd_pkg::INDEX_MSB:0]),
      .first_addr(gfirst),
      .last_addr()
   );

   always_comb begin
      started_d = started_q;
      line_start_d = line_start_q;
      ctrl_pend_d = ctrl_pend_q;
      kind_d = kind_q;
      color_d = color_q;
      glyph_d = glyph_q;
      index_d = index_q + ENTRY_W'(1);
      vsize_d = vsize_q;
      height_d = height_q;
      voff_d = voff_q;
      hshift_d = hshift_q;
      attr_d = attr_q;
      span_d = span_q;
      pending_d = pending_q;
      if (is_line_ctrl) begin
         kind_d = ovwd_pkg::KIND_LINE_CTRL;
         started_d = 1'b1;
         line_start_d = 1'b0;
         vsize_d = w[ovwd_pkg::VSIZE_MSB:ovwd_pkg::VSIZE_LSB];
         height_d = height_of(vsize_d);
         voff_d = w[ovwd_pkg::VPOS_MSB:ovwd_pkg::VPOS_LSB];
         hshift_d = w[ovwd_pkg::HPOS_MSB:0];
      end else if (ctrl_pend_q) begin
         kind_d = ovwd_pkg::KIND_CHAR_CTRL;
         ctrl_pend_d = 1'b0;
         attr_d = dfield;
         span_d = pending_q;
         pending_d = 8'h00;
      end else if (is_ptr) begin
         kind_d = ovwd_pkg::KIND_PTR_RESET;
         // The list wraps to entry zero but the screen state stays.
         index_d = '0;
      end else if (is_line_end) begin
         kind_d = ovwd_pkg::KIND_LINE_END;
         line_start_d = 1'b1;
      end else if (is_screen_end) begin
         kind_d = ovwd_pkg::KIND_SCREEN_END;
         started_d = 1'b0;
         index_d = '0;
         pending_d = 8'h00;
      end else begin
         kind_d = ovwd_pkg::KIND_CHAR;
         color_d = w[ovwd_pkg::COLOR_MSB:ovwd_pkg::COLOR_LSB];
         glyph_d = gfirst;
         ctrl_pend_d = tag;
         pending_d = pending_q + 8'h01;
      end
   end

   assign rd_mux =
      (wb_adr_i == ovwd_pkg::ADDR_WORD) ? {20'h00000, last_word_q} :
      (wb_adr_i == ovwd_pkg::ADDR_CTRL) ? {29'h0, ctrl_pend_q, line_start_q, started_q} :
      (wb_adr_i == ovwd_pkg::ADDR_KIND) ? {29'h0, kind_q} :
      (wb_adr_i == ovwd_pkg::ADDR_CHAR) ? {29'h0, color_q} :
      (wb_adr_i == ovwd_pkg::ADDR_LINE) ?
         {12'h000, height_q, vsize_q, voff_q, hshift_q} :
      (wb_adr_i == ovwd_pkg::ADDR_ATTR) ? {13'h0, span_q, attr_q} :
      (wb_adr_i == ovwd_pkg::ADDR_GLYPH) ? {16'h0000, glyph_q} :
      (wb_adr_i == ovwd_pkg::ADDR_POS) ? {16'h0000, 16'(index_q)} :
      (wb_adr_i == ovwd_pkg::ADDR_ORIGIN) ? {20'h00000, origin_q} :
      32'h00000000;

   // Every access is acked one cycle after it is seen; unmapped reads give zero.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h00000000;
         valid_q <= 1'b0;
      end else begin
         ack_q <= req;
         rdata_q <= rd_mux;
         valid_q <= word_wr;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         origin_q <= 12'h000;
         last_word_q <= 12'h000;
      end else begin
         if (wr && wb_adr_i == ovwd_pkg::ADDR_ORIGIN) begin
            origin_q <= wb_dat_i[11:0];
         end
         if (word_wr) begin
            last_word_q <= w;
         end
      end
   end

   // Soft restart through CTRL bit 0 forces the next word to be a line control.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         started_q <= 1'b0;
         line_start_q <= 1'b0;
         ctrl_pend_q <= 1'b0;
         index_q <= '0;
         pending_q <= 8'h00;
      end else if (wr && wb_adr_i == ovwd_pkg::ADDR_CTRL && wb_dat_i[ovwd_pkg::CTRL_START_BIT]) begin
         started_q <= 1'b0;
         line_start_q <= 1'b0;
         ctrl_pend_q <= 1'b0;
         index_q <= '0;
         pending_q <= 8'h00;
      end else if (word_wr) begin
         started_q <= started_d;
         line_start_q <= line_start_d;
         ctrl_pend_q <= ctrl_pend_d;
         index_q <= index_d;
         pending_q <= pending_d;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         kind_q <= ovwd_pkg::KIND_NONE;
         color_q <= 3'h0;
         glyph_q <= 16'h0000;
         vsize_q <= 4'h0;
         height_q <= 8'h00;
         voff_q <= 4'h0;
         hshift_q <= 4'h0;
         attr_q <= 11'h000;
         span_q <= 8'h00;
      end else if (word_wr) begin
         kind_q <= kind_d;
         color_q <= color_d;
         glyph_q <= glyph_d;
         vsize_q <= vsize_d;
         height_q <= height_d;
         voff_q <= voff_d;
         hshift_q <= hshift_d;
         attr_q <= attr_d;
         span_q <= span_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;
   assign word_valid = valid_q;
   assign word_kind = kind_q;
   assign char_color = color_q;
   assign glyph_addr = glyph_q;
   assign fetch_index = index_q;
   assign line_vsize = vsize_q;
   assign line_height = height_q;
   assign line_voffset = voff_q;
   assign line_hshift = hshift_q;
   assign char_attr = attr_q;
   assign attr_span = span_q;
endmodule // ovwd_decoder
`default_nettype wire

/* File: pkg/ovwd_pkg.sv */
/*
 Constants for the display-list word decoder: word layout, marker codes,
 colour codes, glyph ROM mapping and the register map.
 Assumes a Wishbone slave with 32-bit data and word-aligned byte addresses.
*/
`default_nettype none
package ovwd_pkg;
   localparam int WORD_W = 12;
   localparam int TAG_BIT = 11;
   localparam logic [10:0] MARK_PTR_RESET = 11'h5FF;
   localparam logic [10:0] MARK_LINE_END = 11'h6FF;
   localparam logic [10:0] MARK_SCREEN_END = 11'h7FF;
   localparam int COLOR_LSB = 8;
   localparam int COLOR_MSB = 10;
   localparam int INDEX_MSB = 7;
   localparam int VSIZE_LSB = 8;
   localparam int VSIZE_MSB = 11;
   localparam int VPOS_LSB = 4;
   localparam int VPOS_MSB = 7;
   localparam int HPOS_MSB = 3;
   localparam logic [15:0] GLYPH_BASE = 16'h3000;
   localparam int GLYPH_SHIFT = 5;
   localparam logic [15:0] GLYPH_LAST_OFS = 16'h001F;
   localparam int LINES_PER_SIZE = 16;
   localparam logic [3:0] VSIZE_MAX = 4'hD;
   localparam logic [7:0] ADDR_WORD = 8'h00;
   localparam logic [7:0] ADDR_CTRL = 8'h04;
   localparam logic [7:0] ADDR_KIND = 8'h08;
   localparam logic [7:0] ADDR_CHAR = 8'h0C;
   localparam logic [7:0] ADDR_LINE = 8'h10;
   localparam logic [7:0] ADDR_ATTR = 8'h14;
   localparam logic [7:0] ADDR_GLYPH = 8'h18;
   localparam logic [7:0] ADDR_POS = 8'h1C;
   localparam logic [7:0] ADDR_ORIGIN = 8'h20;
   localparam int CTRL_START_BIT = 0;

   typedef enum logic [2:0] {
      KIND_NONE = 3'b000,
      KIND_CHAR = 3'b001,
      KIND_LINE_CTRL = 3'b010,
      KIND_CHAR_CTRL = 3'b011,
      KIND_LINE_END = 3'b100,
      KIND_SCREEN_END = 3'b101,
      KIND_PTR_RESET = 3'b110
   } ovwd_kind_e;

   typedef enum logic [2:0] {
      COL_BLACK = 3'b000, COL_BLUE = 3'b001, COL_GREEN = 3'b010, COL_CYAN = 3'b011,
      COL_RED = 3'b100, COL_MAGENTA = 3'b101, COL_YELLOW = 3'b110, COL_WHITE = 3'b111
   } ovwd_color_e;
endpackage
`default_nettype wire

/* File: logic/ovwd_glyph_map.sv */
/*
 Maps a glyph index to the first and last glyph_rom address of its block.
 Assumes a purely combinational use by the decoder on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ovwd_glyph_map (
   input wire logic [7:0] index,
   output logic [15:0] first_addr,
   output logic [15:0] last_addr
);
   wire logic [15:0] offset;
   // Each glyph owns 32 consecutive words above the base.
   assign offset = {3'h0, index, 5'h00};
   assign first_addr = ovwd_pkg::GLYPH_BASE + offset;
   assign last_addr = first_addr + ovwd_pkg::GLYPH_LAST_OFS;
endmodule // ovwd_glyph_map
`default_nettype wire

/* File: testbench/ovwd_decoder_props.sv */
/*
 Port checker for ovwd_decoder.
 Assumes a bind from the bench and a master that holds each request until ack.
*/
`timescale 1ns/1ps
`default_nettype none
module ovwd_decoder_props #(
   parameter int ENTRY_W = 8
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic word_valid,
   input wire logic [2:0] word_kind,
   input wire logic [2:0] char_color,
   input wire logic [15:0] glyph_addr,
   input wire logic [ENTRY_W-1:0] fetch_index,
   input wire logic [3:0] line_vsize,
   input wire logic [7:0] line_height,
   input wire logic [3:0] line_voffset,
   input wire logic [3:0] line_hshift
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic lc_q;
   logic pair_q;
   wire logic [11:0] w = wb_dat_i[11:0];
   // A soft restart makes the next word a line control and drops any pairing.
   wire logic restart = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] &&
      wb_adr_i == ovwd_pkg::ADDR_CTRL && wb_dat_i[ovwd_pkg::CTRL_START_BIT];
   // The word is still on the bus in the ack cycle, so no history is kept.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         lc_q <= 1'b1;
         pair_q <= 1'b0;
      end else if (restart) begin
         lc_q <= 1'b1;
         pair_q <= 1'b0;
      end else if (word_valid) begin
         lc_q <= word_kind inside {ovwd_pkg::KIND_LINE_END, ovwd_pkg::KIND_SCREEN_END};
         pair_q <= word_kind == ovwd_pkg::KIND_CHAR && w[11];
      end
   end
   sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_word(k); word_valid && word_kind == k; endsequence
   property p_ack; s_take |=> wb_ack_o ##1 !wb_ack_o; endproperty
   property p_take;
      s_take ##0 (wb_we_i && wb_adr_i == ovwd_pkg::ADDR_WORD) |=> word_valid == wb_sel_i[0];
   endproperty
   property p_mark; s_word(ovwd_pkg::KIND_LINE_END) |-> w == 12'h6FF; endproperty
   property p_char; s_word(ovwd_pkg::KIND_CHAR) |-> char_color == w[10:8]; endproperty
   property p_glyph;
      s_word(ovwd_pkg::KIND_CHAR) |-> glyph_addr == ovwd_pkg::GLYPH_BASE + {w[7:0], 5'h00};
   endproperty
   property p_ptr; s_word(ovwd_pkg::KIND_PTR_RESET) |-> fetch_index == '0; endproperty
   property p_pos; word_valid && lc_q |-> word_kind == ovwd_pkg::KIND_LINE_CTRL; endproperty
   property p_pair; word_valid && pair_q |-> word_kind == ovwd_pkg::KIND_CHAR_CTRL; endproperty
   property p_line;
      s_word(ovwd_pkg::KIND_LINE_CTRL) |-> {line_vsize, line_voffset, line_hshift} == w;
   endproperty
   property p_hgt;
      s_word(ovwd_pkg::KIND_LINE_CTRL) |-> line_height == {line_vsize + 4'h1, 4'h0};
   endproperty
   a_ack: assert property (p_ack) else $error("ack timing wrong");
   a_take: assert property (p_take) else $error("word strobe wrong");
   a_mark: assert property (p_mark) else $error("line end code wrong");
   a_char: assert property (p_char) else $error("colour wrong");
   a_glyph: assert property (p_glyph) else $error("glyph address wrong");
   a_ptr: assert property (p_ptr) else $error("fetch index not cleared");
   a_pos: assert property (p_pos) else $error("line control missed");
   a_pair: assert property (p_pair) else $error("char control missed");
   a_line: assert property (p_line) else $error("line fields wrong");
   a_hgt: assert property (p_hgt) else $error("line height wrong");
endmodule // ovwd_decoder_props
`default_nettype wire

/* File: testbench/ovwd_cpu_model.sv */
/*
 Model of the CPU program that fills the display list over Wishbone.
 Assumes the bench calls access() and bounds every wait with its timeout.
*/
`timescale 1ns/1ps
`default_nettype none
module ovwd_cpu_model (
   input wire logic clock,
   input wire logic wb_ack_i,
   input wire logic [31:0] wb_dat_i,
   output logic wb_cyc_o,
   output logic wb_stb_o,
   output logic wb_we_o,
   output logic [7:0] wb_adr_o,
   output logic [3:0] wb_sel_o,
   output logic [31:0] wb_dat_o
);
   initial begin
      {wb_cyc_o, wb_stb_o, wb_we_o} = 3'h0;
      wb_adr_o = 8'h00;
      wb_sel_o = 4'h0;
      wb_dat_o = 32'h0;
   end
   // A random idle gap makes the program sometimes prompt, sometimes slow.
   task automatic access(input logic we, input logic [7:0] adr, input logic [3:0] sel,
         input logic [31:0] wd, output logic [31:0] rd);
      repeat (1 + $urandom_range(2)) @(posedge clock);
      {wb_cyc_o, wb_stb_o, wb_we_o} <= {2'b11, we};
      wb_adr_o <= adr;
      wb_sel_o <= sel;
      wb_dat_o <= wd;
      do @(posedge clock); while (wb_ack_i !== 1'b1);
      rd = wb_dat_i;
      {wb_cyc_o, wb_stb_o} <= 2'b00;
      // Released data is inverted so a stale word never looks current.
      wb_dat_o <= ~wd;
   endtask
endmodule // ovwd_cpu_model
`default_nettype wire

/* File: testbench/test_ovwd_decoder.sv */
/*
 Self-checking bench for ovwd_decoder; the CPU model writes the list.
 Assumes the checker file is compiled before this one.
*/
`timescale 1ns/1ps
`default_nettype none
module test_ovwd_decoder;
   logic clock, rst_n = 1'b0;
   logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, word_valid;
   logic [7:0] wb_adr_i, fetch_index, line_height, attr_span;
   logic [3:0] wb_sel_i, line_vsize, line_voffset, line_hshift;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [2:0] word_kind, char_color;
   logic [15:0] glyph_addr;
   logic [10:0] char_attr;
   logic [18:0] got;
   logic [21:0] n;
   logic [21:0] notes[$];
   int err_total = 0, compares = 0, cycles = 0;
   ovwd_decoder DUT (.clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .word_valid, .word_kind, .char_color, .glyph_addr,
      .fetch_index, .line_vsize, .line_height, .line_voffset, .line_hshift, .char_attr,
      .attr_span);
   ovwd_cpu_model CPU (.clock, .wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o), .wb_cyc_o(wb_cyc_i),
      .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i),
      .wb_dat_o(wb_dat_i));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic chk(input string what, input logic [18:0] exp, input logic [18:0] seen);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic chk_rd(input string what, input logic [31:0] exp, input logic [31:0] seen);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic put(input logic [11:0] w, input logic [2:0] k, input logic [18:0] v);
      logic [31:0] rd;
      notes.push_back({k, v});
      CPU.access(1'b1, ovwd_pkg::ADDR_WORD, 4'hF, {20'h0, w}, rd);
   endtask
   task automatic ch(input logic [11:0] w);
      put(w, ovwd_pkg::KIND_CHAR, {w[10:8], 16'h3000 + {w[7:0], 5'h00}});
   endtask
   always_comb begin
      case (word_kind)
         3'h1: got = {char_color, glyph_addr};
         3'h2: got = {7'h0, line_vsize, line_voffset, line_hshift};
         3'h3: got = {attr_span, char_attr};
         3'h6: got = 19'(fetch_index);
         default: got = 19'h0;
      endcase
   end
   always @(negedge clock) begin
      if (word_valid === 1'b1) begin
         if (notes.size() == 0) chk("word_valid", 19'h0, 19'h1);
         else begin
            n = notes.pop_front();
            chk("word_kind", 19'(n[21:19]), 19'(word_kind));
            chk("fields", n[18:0], got);
         end
      end
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         err_total++;
         final_report();
      end
   end
   initial begin
      logic [31:0] rd;
      logic [11:0] w;
      void'($urandom(43393));
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      w = {4'($urandom_range(13)), 8'($urandom)};
      put(w, ovwd_pkg::KIND_LINE_CTRL, {7'h0, w});
      for (int i = 0; i < 8; i++) ch({1'b0, 3'(i), 8'($urandom)});
      ch(12'h8FE);
      put(12'h6FF, ovwd_pkg::KIND_CHAR_CTRL, 19'h04EFF);
      ch(12'hDFF);
      put(12'h123, ovwd_pkg::KIND_CHAR_CTRL, 19'h00923);
      put(12'h6FF, ovwd_pkg::KIND_LINE_END, 19'h0);
      put(12'h6FF, ovwd_pkg::KIND_LINE_CTRL, 19'h6FF);
      CPU.access(1'b1, ovwd_pkg::ADDR_WORD, 4'hE, 32'h5FF, rd);
      put(12'h5FF, ovwd_pkg::KIND_PTR_RESET, 19'h0);
      put(12'h7FF, ovwd_pkg::KIND_SCREEN_END, 19'h0);
      put(12'h7FF, ovwd_pkg::KIND_LINE_CTRL, 19'h7FF);
      CPU.access(1'b0, ovwd_pkg::ADDR_KIND, 4'hF, 32'h0, rd);
      chk_rd("kind register", 32'(ovwd_pkg::KIND_LINE_CTRL), rd);
      CPU.access(1'b0, ovwd_pkg::ADDR_LINE, 4'hF, 32'h0, rd);
      chk_rd("line register", 32'h000807FF, rd);
      CPU.access(1'b1, ovwd_pkg::ADDR_CTRL, 4'hF, 32'h00000001, rd);
      put(12'h5FF, ovwd_pkg::KIND_LINE_CTRL, 19'h5FF);
      w = 12'($urandom);
      CPU.access(1'b1, ovwd_pkg::ADDR_ORIGIN, 4'hF, {20'h0, w}, rd);
      CPU.access(1'b0, ovwd_pkg::ADDR_ORIGIN, 4'hF, 32'h0, rd);
      chk_rd("origin register", {20'h0, w}, rd);
      CPU.access(1'b0, 8'h3C, 4'hF, 32'h0, rd);
      chk_rd("unmapped read", 32'h0, rd);
      repeat (2) @(posedge clock);
      chk("pending notes", 19'h0, 19'(notes.size()));
      final_report();
   end
endmodule // test_ovwd_decoder
bind ovwd_decoder ovwd_decoder_props #(.ENTRY_W(ENTRY_W)) u_props (.clock, .rst_n, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .word_valid, .word_kind,
   .char_color, .glyph_addr, .fetch_index, .line_vsize, .line_height, .line_voffset,
   .line_hshift);
`default_nettype wire
